// File: src/tsh_handler.sv
// tsh_handler: task state segment switch, checks and lookups for the core
//
// How it works
// [RULE1] in 64-bit mode a switch by jump, call or interrupt faults
// [RULE2] in 64-bit mode return with nested flag set faults
// [RULE3] a 16-bit segment is valid only with limit 2CH
// [RULE4] 16-bit dispatch keeps the page directory base as it was
// [RULE5] saving to a 16-bit segment stores only low halves of flags, ip
// [RULE6] 16-bit loads give registers with upper halves not kept
// [RULE7] a 16-bit task gets no io permission map
// [RULE8] fixed 16-bit word layout: link 0, ip 14, flags 16, ldt 42
// [RULE9] a switch loads page directory base from the incoming segment; the code loads it only on a jump, call or interrupt to a 32-bit segment
// [RULE10] stack pointers for levels 0-2 read as two halves from offset 4
// [RULE11] seven interrupt stack pointers as halves from offset 36
// [RULE12] io map base is a 16-bit offset from the segment base
// [RULE13] software keeps all segments in shared physical memory
// [RULE14] software builds a 64-bit segment and loads the task register
// [RULE15] software never runs a virtual-8086 task from a 16-bit segment
// [RULE16] nested flag set means return through the previous link
// [RULE17] 64-bit checks apply only while the core reports 64-bit mode
module tsh_handler import tsh_pkg::*; #(
	parameter int AW = 8
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic mode64_i,
	input wire logic sw_req_i,
	input wire tsh_kind_t sw_kind_i,
	input wire logic nt_flag_i,
	input wire logic [15:0] cur_sel_i,
	input wire logic [31:0] cur_base_i,
	input wire logic cur16_i,
	input wire logic [31:0] new_base_i,
	input wire logic new16_i,
	input wire logic [31:0] new_limit_i,
	input wire logic [31:0] save_ip_i,
	input wire logic [31:0] save_flags_i,
	input wire logic lk_req_i,
	input wire logic [3:0] lk_sel_i,
	output logic busy_o,
	output logic sw_done_o,
	output logic lk_done_o,
	output logic fault_o,
	output tsh_cause_t fault_cause_o,
	output logic [15:0] new_sel_o,
	output logic [31:0] new_ip_o,
	output logic [31:0] new_flags_o,
	output logic [15:0] new_ldt_o,
	output logic nested_task_o,
	output logic [31:0] page_directory_base_o,
	output logic io_map_valid_o,
	output logic [15:0] io_map_base_o,
	output logic [63:0] stack_ptr_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic mem_half_o,
	output logic [31:0] mem_addr_o,
	output logic [31:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic [31:0] mem_rdata_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic irq_o
);

	typedef enum logic [3:0] {
		S_IDLE, S_SV_IP, S_SV_FL, S_LINK_WR, S_LD_IP, S_LD_FL, S_LD_LDT,
		S_LD_PDB, S_LINK_RD, S_LK_LO, S_LK_HI, S_DONE
	} tsh_state_t;

	tsh_state_t state_q, state_d;
	tsh_kind_t kind_q;
	tsh_cause_t cause_d;
	logic sw_go, lk_go, lk_bad, mem_st, acc, lk_ist;
	logic cur16_q, new16_q, interrupt_return_instr_q, fault_q, sw_done_q, lk_done_q;
	logic nested_q, iomv_q, lk_seq_q;
	logic [3:0] lk_sel_q;
	logic [15:0] sel_q, ldt_q, iomap_q, cur_sel_q;
	logic [31:0] cbase_q, nbase_q, ip_q, fl_q, sip_q, sfl_q, pdb_q;
	logic [31:0] ctrl_q, prdata_q, lk_off, lk_rel, rd_low;
	logic [63:0] ptr_q;
	logic [NUM_EV-1:0] irq_st, irq_en;
	tsh_cause_t cause_q;

	////////////////////////////////////////////////////////////////////////
	// request acceptance and checks

	assign busy_o = (state_q != S_IDLE);
	assign sw_go = ce_i && sw_req_i && !busy_o;
	// a switch request has priority; a lookup waits for the next free cycle
	assign lk_go = ce_i && lk_req_i && !sw_req_i && !busy_o;
	assign lk_bad = (lk_sel_i > LK_IOMAP);

	always_comb begin
		cause_d = C_NONE;
		if (!ctrl_q[0]) begin
			cause_d = C_DISABLED;
		end else if (mode64_i) begin // RULE17
			if (sw_kind_i != K_INTERRUPT_RETURN_INSTR) begin
				cause_d = C_MODE64; // RULE1
			end else if (nt_flag_i) begin
				cause_d = C_INTERRUPT_RETURN_INSTR_NT; // RULE2
			end
		end else if (sw_kind_i != K_INTERRUPT_RETURN_INSTR && new16_i &&
				new_limit_i != T16_LIMIT) begin
			cause_d = C_LIMIT16; // RULE3
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			S_IDLE: begin
				if (sw_go) begin
					if (cause_d != C_NONE) begin
						state_d = S_IDLE;
					end else if (sw_kind_i == K_INTERRUPT_RETURN_INSTR) begin
						// nested return walks back through the link
						state_d = nt_flag_i ? S_LINK_RD : S_DONE; // RULE16
					end else begin
						state_d = S_SV_IP;
					end
				end else if (lk_go) begin
					state_d = lk_bad ? S_IDLE : S_LK_LO;
				end
			end
			S_SV_IP: if (mem_ack_i) state_d = S_SV_FL;
			S_SV_FL: begin
				if (mem_ack_i) begin
					state_d = (kind_q == K_JMP) ? S_LD_IP : S_LINK_WR;
				end
			end
			S_LINK_WR: if (mem_ack_i) state_d = S_LD_IP;
			S_LD_IP: if (mem_ack_i) state_d = S_LD_FL;
			S_LD_FL: if (mem_ack_i) state_d = S_LD_LDT;
			S_LD_LDT: begin
				if (mem_ack_i) begin
					state_d = new16_q ? S_DONE : S_LD_PDB; // RULE4
				end
			end
			S_LD_PDB: if (mem_ack_i) state_d = S_DONE;
			S_LINK_RD: if (mem_ack_i) state_d = S_DONE;
			S_LK_LO: begin
				if (mem_ack_i) begin
					state_d = (lk_sel_q == LK_IOMAP) ? S_DONE : S_LK_HI;
				end
			end
			S_LK_HI: if (mem_ack_i) state_d = S_DONE;
			S_DONE: state_d = S_IDLE;
			default: state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state_q <= S_IDLE;
		end else if (ce_i) begin
			state_q <= state_d;
		end
	end

	// request context, held for the whole sequence
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			kind_q <= K_JMP;
			cur16_q <= 1'b0;
			new16_q <= 1'b0;
			cbase_q <= 32'h0;
			nbase_q <= 32'h0;
			sip_q <= 32'h0;
			sfl_q <= 32'h0;
			cur_sel_q <= 16'h0;
			lk_sel_q <= 4'h0;
		end else if (sw_go) begin
			kind_q <= sw_kind_i;
			cur16_q <= cur16_i;
			new16_q <= new16_i;
			cbase_q <= cur_base_i;
			nbase_q <= new_base_i;
			sip_q <= save_ip_i;
			sfl_q <= save_flags_i;
			cur_sel_q <= cur_sel_i;
		end else if (lk_go) begin
			cbase_q <= cur_base_i;
			lk_sel_q <= lk_sel_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// memory port toward the segments in system memory

	assign mem_st = (state_q != S_IDLE) && (state_q != S_DONE);
	assign acc = ce_i && mem_req_o && mem_ack_i;
	assign lk_ist = (lk_sel_q >= LK_IST1);
	assign lk_rel = {25'h0, lk_sel_q, 3'h0} - {25'h0, LK_IST1, 3'h0};
	assign lk_off = (lk_sel_q == LK_IOMAP) ? T64_IOMAP :
		lk_ist ? T64_IST1 + lk_rel : // RULE11
		T64_RSP0 + {25'h0, lk_sel_q, 3'h0}; // RULE10

	always_comb begin
		mem_req_o = mem_st;
		mem_we_o = 1'b0;
		mem_half_o = 1'b0;
		mem_addr_o = 32'h0;
		mem_wdata_o = 32'h0;
		case (state_q)
			S_SV_IP: begin
				mem_we_o = 1'b1;
				mem_half_o = cur16_q;
				mem_addr_o = cbase_q + (cur16_q ? T16_IP : T32_IP); // RULE8
				mem_wdata_o = cur16_q ? {16'h0, sip_q[15:0]} : sip_q; // RULE5
			end
			S_SV_FL: begin
				mem_we_o = 1'b1;
				mem_half_o = cur16_q;
				mem_addr_o = cbase_q + (cur16_q ? T16_FLAGS : T32_FLAGS);
				mem_wdata_o = cur16_q ? {16'h0, sfl_q[15:0]} : sfl_q; // RULE5
			end
			S_LINK_WR: begin
				mem_we_o = 1'b1;
				mem_half_o = 1'b1;
				mem_addr_o = nbase_q + T16_LINK;
				mem_wdata_o = {16'h0, cur_sel_q};
			end
			S_LD_IP: begin
				mem_half_o = new16_q;
				mem_addr_o = nbase_q + (new16_q ? T16_IP : T32_IP);
			end
			S_LD_FL: begin
				mem_half_o = new16_q;
				mem_addr_o = nbase_q + (new16_q ? T16_FLAGS : T32_FLAGS);
			end
			S_LD_LDT: begin
				mem_half_o = 1'b1;
				mem_addr_o = nbase_q + (new16_q ? T16_LDT : T32_LDT); // RULE8
			end
			S_LD_PDB: mem_addr_o = nbase_q + T32_PDB;
			S_LINK_RD: begin
				mem_half_o = 1'b1;
				mem_addr_o = cbase_q + T16_LINK; // RULE16
			end
			S_LK_LO: begin
				mem_half_o = (lk_sel_q == LK_IOMAP);
				mem_addr_o = cbase_q + lk_off;
			end
			S_LK_HI: mem_addr_o = cbase_q + lk_off + T64_HALF;
			default: mem_addr_o = 32'h0;
		endcase
	end

	// 16-bit words land in the low half; the upper half is not kept
	assign rd_low = {16'h0, mem_rdata_i[15:0]}; // RULE6

	////////////////////////////////////////////////////////////////////////
	// loaded state

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ip_q <= 32'h0;
			fl_q <= 32'h0;
			ldt_q <= 16'h0;
			sel_q <= 16'h0;
		end else if (acc) begin
			case (state_q)
				S_LD_IP: ip_q <= new16_q ? rd_low : mem_rdata_i; // RULE6
				S_LD_FL: fl_q <= new16_q ? rd_low : mem_rdata_i; // RULE6
				S_LD_LDT: ldt_q <= mem_rdata_i[15:0];
				S_LINK_RD: sel_q <= mem_rdata_i[15:0]; // RULE16
				default: sel_q <= sel_q;
			endcase
		end
	end

	// only a 32-bit segment carries a page directory base
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pdb_q <= PDB_RST;
		end else if (acc && state_q == S_LD_PDB) begin
			pdb_q <= mem_rdata_i; // RULE9
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ptr_q <= 64'h0;
			iomap_q <= 16'h0;
		end else if (acc && state_q == S_LK_LO) begin
			if (lk_sel_q == LK_IOMAP) begin
				iomap_q <= mem_rdata_i[15:0]; // RULE12
			end else begin
				ptr_q <= {32'h0, mem_rdata_i}; // RULE10
			end
		end else if (acc && state_q == S_LK_HI) begin
			ptr_q[63:32] <= mem_rdata_i; // RULE11
		end
	end

	// nesting and io map availability of the task now running
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			nested_q <= 1'b0;
			iomv_q <= 1'b0;
		end else if (ce_i && state_q == S_DONE && !lk_seq_q) begin
			if (!interrupt_return_instr_q) begin
				nested_q <= (kind_q != K_JMP);
				iomv_q <= !new16_q; // RULE7
			end else begin
				nested_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// answers and faults

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			fault_q <= 1'b0;
			cause_q <= C_NONE;
			sw_done_q <= 1'b0;
			lk_done_q <= 1'b0;
			interrupt_return_instr_q <= 1'b0;
		end else if (ce_i) begin
			fault_q <= (sw_go && cause_d != C_NONE) || (lk_go && lk_bad);
			if (sw_go && cause_d != C_NONE) begin
				cause_q <= cause_d;
			end else if (lk_go && lk_bad) begin
				cause_q <= C_BAD_INDEX;
			end
			if (sw_go) begin
				interrupt_return_instr_q <= (sw_kind_i == K_INTERRUPT_RETURN_INSTR);
			end else if (lk_go) begin
				interrupt_return_instr_q <= 1'b1;
			end
			sw_done_q <= (state_q == S_DONE) && !lk_seq_q;
			lk_done_q <= (state_q == S_DONE) && lk_seq_q;
		end
	end

	// remembers whether the finishing sequence was a lookup
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			lk_seq_q <= 1'b0;
		end else if (sw_go) begin
			lk_seq_q <= 1'b0;
		end else if (lk_go) begin
			lk_seq_q <= 1'b1;
		end
	end

	assign fault_o = fault_q;
	assign fault_cause_o = cause_q;
	assign sw_done_o = sw_done_q;
	assign lk_done_o = lk_done_q;
	assign new_sel_o = sel_q;
	assign new_ip_o = ip_q;
	assign new_flags_o = fl_q;
	assign new_ldt_o = ldt_q;
	assign nested_task_o = nested_q;
	assign page_directory_base_o = pdb_q;
	assign io_map_valid_o = iomv_q;
	assign io_map_base_o = iomap_q;
	assign stack_ptr_o = ptr_q;

	////////////////////////////////////////////////////////////////////////
	// register bus: zero wait states, read data caught in the setup cycle

	logic wr_acc, setup, mapped;
	logic [7:0] a8;
	assign a8 = 8'(paddr_i);
	assign setup = ce_i && psel_i && !penable_i;
	assign wr_acc = ce_i && psel_i && penable_i && pwrite_i;
	assign mapped = (a8 <= REG_PDB) && (a8[1:0] == 2'h0);
	assign pready_o = ce_i;
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign prdata_o = prdata_q;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ctrl_q <= CTRL_RST;
		end else if (wr_acc && a8 == REG_CTRL) begin
			ctrl_q <= {31'h0, pwdata_i[0]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			prdata_q <= 32'h0;
		end else if (setup) begin
			case (a8)
				REG_CTRL: prdata_q <= ctrl_q;
				REG_STATE: prdata_q <= {21'h0, nested_q, iomv_q, busy_o,
					5'h0, cause_q};
				REG_IRQ_ST: prdata_q <= {29'h0, irq_st};
				REG_IRQ_EN: prdata_q <= {29'h0, irq_en};
				REG_PDB: prdata_q <= pdb_q;
				default: prdata_q <= 32'h0;
			endcase
		end
	end

	tsh_irq #(
		.N(NUM_EV)
	) u_irq (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.event_i({lk_done_q, sw_done_q, fault_q}),
		.clear_wr_i(wr_acc && a8 == REG_IRQ_CLR),
		.enable_wr_i(wr_acc && a8 == REG_IRQ_EN),
		.wdata_i(pwdata_i[NUM_EV-1:0]),
		.status_o(irq_st),
		.enable_o(irq_en),
		.irq_o(irq_o)
	);

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_sw_ok;
		sw_go && ctrl_q[0] && !mode64_i && sw_kind_i != K_INTERRUPT_RETURN_INSTR &&
			(!new16_i || new_limit_i == T16_LIMIT);
	endsequence
	sequence s_lk_rsp;
		lk_go && lk_sel_i < LK_IST1;
	endsequence
	sequence s_lk_ist;
		lk_go && lk_sel_i >= LK_IST1 && lk_sel_i < LK_IOMAP;
	endsequence

	a_mode64_switch: assert property (sw_go && ctrl_q[0] && mode64_i && // RULE1
		sw_kind_i != K_INTERRUPT_RETURN_INSTR |=> fault_o && fault_cause_o == C_MODE64 &&
		!busy_o) else $error("64-bit switch not refused");
	a_mode64_interrupt_return_instr: assert property (sw_go && ctrl_q[0] && mode64_i && // RULE2
		sw_kind_i == K_INTERRUPT_RETURN_INSTR && nt_flag_i |=> fault_o &&
		fault_cause_o == C_INTERRUPT_RETURN_INSTR_NT) else $error("nested return not refused");
	a_limit_16: assert property (s_sw_ok |=> !fault_o) // RULE3
		else $error("valid 16-bit limit refused");
	a_limit_bad: assert property (sw_go && ctrl_q[0] && !mode64_i && // RULE3
		new16_i && new_limit_i != T16_LIMIT && sw_kind_i != K_INTERRUPT_RETURN_INSTR |=>
		fault_cause_o == C_LIMIT16) else $error("bad 16-bit limit taken");
	a_pdb_keep: assert property (busy_o && new16_q && !lk_seq_q |=> // RULE4
		$stable(pdb_q)) else $error("16-bit dispatch changed page base");
	a_save_low: assert property (mem_req_o && mem_we_o && cur16_q && // RULE5
		(state_q == S_SV_IP || state_q == S_SV_FL) |-> mem_half_o &&
		mem_wdata_o[31:16] == 16'h0) else $error("upper half saved");
	a_load_trunc: assert property (sw_done_o && new16_q && !interrupt_return_instr_q |-> // RULE6
		new_ip_o[31:16] == 16'h0 && new_flags_o[31:16] == 16'h0)
		else $error("16-bit load kept upper half");
	a_iomap_16: assert property (sw_done_o && !interrupt_return_instr_q |-> // RULE7
		io_map_valid_o == !new16_q) else $error("io map state wrong");
	a_ldt_offset: assert property (state_q == S_LD_LDT && new16_q |-> // RULE8
		mem_addr_o == nbase_q + 32'h0000_002a) else $error("ldt offset");
	a_pdb_load: assert property (acc && state_q == S_LD_PDB |=> // RULE9
		pdb_q == $past(mem_rdata_i)) else $error("page base not loaded");
	a_rsp_addr: assert property (s_lk_rsp |=> mem_req_o && // RULE10
		mem_addr_o == $past(cur_base_i) + 32'h4 + 32'(lk_sel_q) * 8)
		else $error("stack pointer address");
	a_ist_addr: assert property (s_lk_ist |=> mem_req_o && // RULE11
		mem_addr_o == $past(cur_base_i) + 32'd12 + 32'(lk_sel_q) * 8)
		else $error("interrupt stack address");
	a_interrupt_return_instr_link: assert property (sw_go && ctrl_q[0] && !mode64_i && // RULE16
		sw_kind_i == K_INTERRUPT_RETURN_INSTR && nt_flag_i |=> state_q == S_LINK_RD &&
		mem_addr_o == $past(cur_base_i)) else $error("link not followed");
	a_legacy_ok: assert property (s_sw_ok |=> busy_o // RULE17
		##1 mem_req_o) else $error("legacy switch not started");

endmodule : tsh_handler

// File: src/tsh_irq.sv
// tsh_irq: sticky event status, enable mask and level interrupt
module tsh_irq import tsh_pkg::*; #(
	parameter int N = NUM_EV
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic [N-1:0] event_i,
	input wire logic clear_wr_i,
	input wire logic enable_wr_i,
	input wire logic [N-1:0] wdata_i,
	output wire logic [N-1:0] status_o,
	output wire logic [N-1:0] enable_o,
	output wire logic irq_o
);

	for (genvar i = 0; i < N; i++) begin : g_bit
		logic st_q;
		logic en_q;
		always_ff @(posedge clk_i) begin
			if (!resetn_i) begin
				st_q <= 1'b0;
			end else if (ce_i) begin
				// a new event beats a clear in the same cycle
				st_q <= event_i[i] | (st_q & ~(clear_wr_i & wdata_i[i]));
			end
		end
		always_ff @(posedge clk_i) begin
			if (!resetn_i) begin
				en_q <= 1'b0;
			end else if (ce_i && enable_wr_i) begin
				en_q <= wdata_i[i];
			end
		end
		assign status_o[i] = st_q;
		assign enable_o[i] = en_q;
	end

	assign irq_o = |(status_o & enable_o);

endmodule : tsh_irq

// File: src/tsh_pkg.sv
// tsh_pkg: offsets, reset values and types of the task state segment handler
package tsh_pkg;

	////////////////////////////////////////////////////////////////////////
	// legacy 16-bit segment, byte offsets of 16-bit words
	localparam logic [31:0] T16_LINK = 32'h0000_0000;
	localparam logic [31:0] T16_SP0 = 32'h0000_0002;
	localparam logic [31:0] T16_IP = 32'h0000_000e;
	localparam logic [31:0] T16_FLAGS = 32'h0000_0010;
	localparam logic [31:0] T16_GPR0 = 32'h0000_0012;
	localparam logic [31:0] T16_ES = 32'h0000_0022;
	localparam logic [31:0] T16_LDT = 32'h0000_002a;
	localparam logic [31:0] T16_LIMIT = 32'h0000_002c;

	// 32-bit segment offsets used by a full switch
	localparam logic [31:0] T32_PDB = 32'h0000_001c;
	localparam logic [31:0] T32_IP = 32'h0000_0020;
	localparam logic [31:0] T32_FLAGS = 32'h0000_0024;
	localparam logic [31:0] T32_LDT = 32'h0000_0060;

	// 64-bit segment offsets
	localparam logic [31:0] T64_RSP0 = 32'h0000_0004;
	localparam logic [31:0] T64_IST1 = 32'h0000_0024;
	localparam logic [31:0] T64_HALF = 32'h0000_0004;
	localparam logic [31:0] T64_IOMAP = 32'h0000_0066;

	// lookup selector codes: 0..2 stack levels, 3..9 table 1..7, 10 io map
	localparam logic [3:0] LK_IST1 = 4'h3;
	localparam logic [3:0] LK_IOMAP = 4'ha;

	////////////////////////////////////////////////////////////////////////
	// register map, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATE = 8'h04;
	localparam logic [7:0] REG_IRQ_ST = 8'h08;
	localparam logic [7:0] REG_IRQ_CLR = 8'h0c;
	localparam logic [7:0] REG_IRQ_EN = 8'h10;
	localparam logic [7:0] REG_PDB = 8'h14;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [31:0] PDB_RST = 32'h0000_0000;

	// event bits
	localparam int NUM_EV = 3;
	localparam int EV_FAULT = 0;
	localparam int EV_SWITCH = 1;
	localparam int EV_LOOKUP = 2;

	typedef enum logic [2:0] {
		K_JMP, K_CALL, K_SWINT, K_HWINT, K_INTERRUPT_RETURN_INSTR
	} tsh_kind_t;

	typedef enum logic [2:0] {
		C_NONE, C_DISABLED, C_MODE64, C_INTERRUPT_RETURN_INSTR_NT, C_LIMIT16, C_BAD_INDEX
	} tsh_cause_t;

endpackage : tsh_pkg

// File: testbench/tsh_handler_tb_top.sv
// tsh_handler_tb_top: self-checking bench for the segment handler
module tsh_handler_tb_top import tsh_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] CB = 32'h0000_0100;
	localparam logic [31:0] NB = 32'h0000_0200;
	logic clk_i, resetn_i, ce_i, mode64_i, sw_req_i, nt_flag_i, cur16_i;
	logic new16_i, lk_req_i, busy_o, sw_done_o, lk_done_o, fault_o, slow;
	logic nested_task_o, io_map_valid_o, mem_req_o, mem_we_o, mem_half_o;
	logic mem_ack_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
	logic e;
	logic [3:0] lk_sel_i;
	logic [7:0] paddr_i;
	logic [15:0] cur_sel_i, new_sel_o, new_ldt_o, io_map_base_o;
	logic [31:0] cur_base_i, new_base_i, new_limit_i, save_ip_i, save_flags_i;
	logic [31:0] new_ip_o, new_flags_o, page_directory_base_o, mem_addr_o;
	logic [31:0] mem_wdata_o, mem_rdata_i, pwdata_i, prdata_o, r, ad, pdb;
	logic [63:0] stack_ptr_o;
	tsh_kind_t sw_kind_i;
	tsh_cause_t fault_cause_o;
	int fails, n_compared, a;
	int ew[$];
	`define CHK(g, x) check((g) === (x))

	tsh_handler i_dut (.*);
	tsh_mem_model i_mem (.clk_i, .resetn_i, .slow_i(slow),
		.mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_half_i(mem_half_o),
		.mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
		.mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input bit ok);
		n_compared++;
		if (!ok) begin
			fails++;
			$display("wrong value at %0t: output mismatch", $time);
		end
	endtask : check

	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results

	function automatic logic [31:0] rd(input logic [31:0] at, input int n);
		logic [31:0] v;
		v = 32'h0;
		for (int i = 0; i < n; i++)
			v[8*i +: 8] = i_mem.mem[at + i];
		return v;
	endfunction : rd

	task automatic wait_end();
		int i;
		for (i = 0; i < 300; i++) begin
			#1;
			if (sw_done_o || lk_done_o || fault_o)
				break;
			@(posedge clk_i);
		end
		if (i == 300) begin
			fails++;
			results();
		end
	endtask : wait_end

	task automatic sw(input tsh_kind_t k, input logic m, nt, n16,
		input logic [7:0] lim);
		@(posedge clk_i);
		i_mem.wq.delete();
		{mode64_i, nt_flag_i, new16_i} <= {m, nt, n16};
		sw_kind_i <= k;
		new_limit_i <= {24'h0, lim};
		save_ip_i <= $urandom;
		save_flags_i <= $urandom;
		sw_req_i <= 1'b1;
		@(posedge clk_i);
		sw_req_i <= 1'b0;
		wait_end();
	endtask : sw

	task automatic lk(input logic [3:0] s);
		@(posedge clk_i);
		lk_sel_i <= s;
		lk_req_i <= 1'b1;
		@(posedge clk_i);
		lk_req_i <= 1'b0;
		wait_end();
	endtask : lk

	task automatic apb(input logic w, input logic [7:0] at, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		{psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, at, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_i);
			if (pready_o)
				break;
		end
		r = prdata_o;
		e = pslverr_o;
		{psel_i, penable_i} <= 2'b00;
		#1;
		if (i == 50) begin
			fails++;
			results();
		end
	endtask : apb

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(35));
		{resetn_i, ce_i, mode64_i, sw_req_i, nt_flag_i, cur16_i} = 6'b010001;
		{new16_i, lk_req_i, slow, psel_i, penable_i, pwrite_i} = 6'b0;
		sw_kind_i = K_JMP;
		{lk_sel_i, paddr_i, pwdata_i} = 44'h0;
		{cur_sel_i, cur_base_i, new_base_i} = {16'h0028, CB, NB};
		{new_limit_i, save_ip_i, save_flags_i} = 96'h0;
		{fails, n_compared} = 64'h0;
		// both segments, 64-bit fields included, sit in one shared area
		for (a = 0; a < 512; a++)
			i_mem.mem[CB + a] = 8'($urandom);
		repeat (4) @(posedge clk_i);
		resetn_i <= 1'b1;
		apb(1'b0, REG_CTRL, 32'h0);
		`CHK(r, CTRL_RST);
		apb(1'b1, REG_PDB, 32'hffff_ffff);
		apb(1'b0, REG_PDB, 32'h0);
		`CHK(r, PDB_RST);
		apb(1'b0, 8'h18, 32'h0);
		`CHK({e, r}, 33'h1_0000_0000);
		$display("test registers done");
		sw(K_JMP, 1'b0, 1'b0, 1'b0, 8'h68);
		`CHK(page_directory_base_o, rd(NB + T32_PDB, 4));
		`CHK(new_ip_o, rd(NB + T32_IP, 4));
		apb(1'b0, REG_PDB, 32'h0);
		`CHK(r, rd(NB + T32_PDB, 4));
		for (a = 0; a < 4; a++) begin
			slow = a[0];
			pdb = page_directory_base_o;
			sw(tsh_kind_t'(a), 1'b0, 1'b0, 1'b1, 8'h2c);
			ew = {CB + T16_IP, CB + T16_FLAGS};
			if (a != 0)
				ew.push_back(NB + T16_LINK);
			`CHK(i_mem.wq.size(), ew.size());
			foreach (ew[j]) `CHK(i_mem.wq[j], ew[j]);
			`CHK(rd(CB + T16_IP, 2), {16'h0, save_ip_i[15:0]});
			`CHK(rd(CB + T16_FLAGS, 2), {16'h0, save_flags_i[15:0]});
			`CHK(new_ip_o, rd(NB + T16_IP, 2));
			`CHK(new_flags_o, rd(NB + T16_FLAGS, 2));
			`CHK(new_ldt_o, rd(NB + T16_LDT, 2));
			`CHK(page_directory_base_o, pdb);
			`CHK(io_map_valid_o, 1'b0);
			`CHK(nested_task_o, a != 0);
			if (a != 0) `CHK(rd(NB, 2), {16'h0, cur_sel_i});
		end
		sw(K_INTERRUPT_RETURN_INSTR, 1'b0, 1'b1, 1'b1, 8'h2c);
		`CHK(new_sel_o, rd(CB + T16_LINK, 2));
		`CHK({sw_done_o, nested_task_o, busy_o}, 3'b100);
		$display("test switches done");
		for (a = 0; a < 5; a++) begin
			sw(tsh_kind_t'(a), 1'b1, 1'b1, 1'b1, 8'h2c);
			`CHK({fault_o, fault_cause_o}, {1'b1, a < 4 ? C_MODE64 : C_INTERRUPT_RETURN_INSTR_NT});
			`CHK(i_mem.wq.size(), 0);
		end
		sw(K_INTERRUPT_RETURN_INSTR, 1'b1, 1'b0, 1'b1, 8'h2c);
		`CHK({sw_done_o, fault_o}, 2'b10);
		for (a = 43; a < 46; a += 2) begin
			sw(K_CALL, 1'b0, 1'b0, 1'b1, 8'(a));
			`CHK({fault_o, fault_cause_o}, {1'b1, C_LIMIT16});
		end
		apb(1'b1, REG_CTRL, 32'h0);
		sw(K_JMP, 1'b0, 1'b0, 1'b1, 8'h2c);
		`CHK({fault_o, fault_cause_o}, {1'b1, C_DISABLED});
		apb(1'b1, REG_CTRL, 32'h1);
		$display("test refusals done");
		apb(1'b1, REG_IRQ_CLR, 32'h7);
		apb(1'b1, REG_IRQ_EN, 32'h1);
		`CHK(irq_o, 1'b0);
		sw(K_JMP, 1'b0, 1'b0, 1'b1, 8'h2b);
		@(posedge clk_i);
		#1;
		`CHK(irq_o, 1'b1);
		apb(1'b1, REG_IRQ_EN, 32'h0);
		`CHK(irq_o, 1'b0);
		apb(1'b1, REG_IRQ_CLR, 32'h7);
		apb(1'b0, REG_IRQ_ST, 32'h0);
		`CHK(r, 32'h0);
		$display("test interrupts done");
		slow = 1'b1;
		for (a = 0; a < 12; a++) begin
			lk(4'(a));
			ad = a < 3 ? CB + T64_RSP0 + 8 * a : CB + T64_IST1 + 8 * (a - 3);
			if (a < 10) `CHK(stack_ptr_o, {rd(ad + 4, 4), rd(ad, 4)});
			else if (a == 10) `CHK(io_map_base_o, rd(CB + T64_IOMAP, 2));
			else `CHK({fault_o, fault_cause_o}, {1'b1, C_BAD_INDEX});
		end
		$display("test lookups done");
		results();
	end
endmodule : tsh_handler_tb_top

// File: testbench/tsh_mem_model.sv
// tsh_mem_model: shared system memory holding the task state segments
module tsh_mem_model (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic slow_i,
	input wire logic mem_req_i,
	input wire logic mem_we_i,
	input wire logic mem_half_i,
	input wire logic [31:0] mem_addr_i,
	input wire logic [31:0] mem_wdata_i,
	output logic mem_ack_o,
	output logic [31:0] mem_rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [int];
	int wq[$];
	int wait_q;
	logic [15:0] lo;

	////////////////////////////////////////////////////////////////////////
	// one flat byte store for every task, so no address moves mid-switch
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			mem_ack_o <= 1'b0;
			mem_rdata_o <= 32'h0;
			wait_q <= 0;
		end else if (mem_req_i && !mem_ack_o && wait_q == 0) begin
			lo = {mem[mem_addr_i + 1], mem[mem_addr_i]};
			mem_ack_o <= 1'b1;
			wait_q <= slow_i ? int'($urandom_range(3)) : 0;
			if (mem_we_i) begin
				wq.push_back(mem_addr_i);
				for (int i = 0; i < (mem_half_i ? 2 : 4); i++)
					mem[mem_addr_i + i] = mem_wdata_i[8*i +: 8];
				mem_rdata_o <= ~mem_rdata_o;
			end else if (mem_half_i) begin
				// upper half is junk, never a copy of the low half
				mem_rdata_o <= {~lo, lo};
			end else begin
				mem_rdata_o <= {mem[mem_addr_i + 3], mem[mem_addr_i + 2], lo};
			end
		end else begin
			// idle bus shows a changing pattern, not the last data
			mem_ack_o <= 1'b0;
			mem_rdata_o <= ~mem_rdata_o;
			if (mem_req_i && !mem_ack_o)
				wait_q <= wait_q - 1;
		end
	end
endmodule : tsh_mem_model
